/* include/bmei_irq_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface bmei_irq_if #(
    parameter int N_LINES = 4
);
    logic [N_LINES-1:0] pin_n;
    logic [N_LINES-1:0] edge_cfg;
    logic               armed;
    logic [N_LINES-1:0] event_hit;

    modport det (
        input  pin_n,
        input  edge_cfg,
        input  armed,
        output event_hit
    );

    modport ctl (
        output pin_n,
        output edge_cfg,
        output armed,
        input  event_hit
    );
endinterface

`default_nettype wire

/* include/bmei_params.svh */
`ifndef BMEI_PARAMS_SVH
`define BMEI_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets (haddr[7:0])
// ------------------------------------------------------------
`define BMEI_OFS_MODE     8'h00
`define BMEI_OFS_STATUS   8'h04
`define BMEI_OFS_EDGE     8'h08
`define BMEI_OFS_MASK     8'h0C
`define BMEI_OFS_STANDBY  8'h10

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define BMEI_LINES        4
`define BMEI_MODE_RST     4'h0
`define BMEI_STATUS_RST   4'h0
`define BMEI_EDGE_RST     4'h0
`define BMEI_MASK_RST     4'h0
`define BMEI_PIN_IDLE     4'hF
`define BMEI_PHASE_RST    2'h0
`define BMEI_CMD_WAIT     32'h0000_0001
`define BMEI_CMD_STOP     32'h0000_0002

`endif

/* include/bmei_pkg.sv */
`include "bmei_params.svh"

package bmei_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP
    } bmei_std_t;

    typedef struct packed {
        logic [`BMEI_LINES-1:0] prev;
    } bmei_det_t;

    typedef struct packed {
        logic [3:0]             mode;
        logic                   armed;
        logic [`BMEI_LINES-1:0] status;
        logic [`BMEI_LINES-1:0] edge_cfg;
        logic [`BMEI_LINES-1:0] mask;
        bmei_std_t              std;
        logic [1:0]             phase;
        logic                   wr_pend;
        logic [7:0]             wr_addr;
        logic [31:0]            hrdata;
        logic                   hreadyout;
        logic                   hresp;
        logic                   irq;
    } bmei_state_t;

endpackage

/* rtl/bmei_line_det.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bmei_params.svh"

module bmei_line_det
    import bmei_pkg::*;
#(
    parameter int N_LINES = 4
) (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    bmei_irq_if.det     lines
);

    bmei_det_t s_q;
    bmei_det_t s_d;

    if (N_LINES != `BMEI_LINES) begin : g_bad_lines
        $error("bmei_line_det: N_LINES must equal the pin count");
    end

    // ------------------------------------------------------------
    // Per-line request detection
    // ------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.prev = lines.pin_n;
        for (int i = 0; i < N_LINES; i++) begin
            if (!lines.armed) begin
                lines.event_hit[i] = 1'b0;
            end else if (lines.edge_cfg[i]) begin
                lines.event_hit[i] = s_q.prev[i] & ~lines.pin_n[i];
            end else begin
                lines.event_hit[i] = ~lines.pin_n[i];
            end
        end
    end

    // Idle-high reset value is replaced from the pins on the first edge, while armed still blocks edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.prev <= `BMEI_PIN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

/* rtl/bmei_top.sv */
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "bmei_params.svh"

module bmei_top
    import bmei_pkg::*;
#(
    parameter int N_LINES = 4
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [3:0]        ext_int_req_n,
    output logic [3:0]             boot_mode,
    output logic                   irq,
    output bmei_pkg::bmei_std_t    std_state,
    output logic [1:0]             clk_phase
);

    bmei_state_t s_q;
    bmei_state_t s_d;
    logic        wr_now;
    logic [3:0]  wake_low;

    bmei_irq_if #(.N_LINES(N_LINES)) lines ();

    if (N_LINES != `BMEI_LINES) begin : g_bad_lines
        $error("bmei_top: N_LINES must equal the pin count");
    end

    assign lines.pin_n    = ext_int_req_n;
    assign lines.edge_cfg = s_q.edge_cfg;
    assign lines.armed    = s_q.armed;

    bmei_line_det #(.N_LINES(N_LINES)) u_det (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lines   (lines)
    );

    function automatic logic [31:0] read_word(input bmei_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == `BMEI_OFS_MODE) begin
            r[3:0] = s.mode;
        end else if (a == `BMEI_OFS_STATUS) begin
            r[3:0] = s.status;
        end else if (a == `BMEI_OFS_EDGE) begin
            r[3:0] = s.edge_cfg;
        end else if (a == `BMEI_OFS_MASK) begin
            r[3:0] = s.mask;
        end else if (a == `BMEI_OFS_STANDBY) begin
            r[1:0] = s.std;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] clr;
        clr      = 4'h0;
        s_d      = s_q;
        wr_now   = s_q.wr_pend;
        wake_low = ~ext_int_req_n;

        s_d.phase = 2'(s_q.phase + 2'h1);

        // First edge after release latches the strap, then pins serve as requests
        if (!s_q.armed) begin
            s_d.mode  = ext_int_req_n;
            s_d.armed = 1'b1;
        end

        // Data phase of a write
        if (wr_now) begin
            if (s_q.wr_addr == `BMEI_OFS_STATUS) begin
                clr = hwdata[3:0];
            end else if (s_q.wr_addr == `BMEI_OFS_EDGE) begin
                s_d.edge_cfg = hwdata[3:0];
            end else if (s_q.wr_addr == `BMEI_OFS_MASK) begin
                s_d.mask = hwdata[3:0];
            end else if (s_q.wr_addr == `BMEI_OFS_STANDBY) begin
                if (hwdata == `BMEI_CMD_WAIT) begin
                    s_d.std = ST_WAIT;
                end else if (hwdata == `BMEI_CMD_STOP) begin
                    s_d.std = ST_STOP;
                end
            end
        end

        // Set wins over a same-cycle write-one-to-clear
        s_d.status = (s_q.status & ~clr) | lines.event_hit;

        // Wake on asserted pin level, independent of the mask
        case (s_q.std)
            ST_STOP: begin
                if (wake_low[0]) begin
                    s_d.std = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (|wake_low) begin
                    s_d.std = ST_RUN;
                end
            end
            default: begin
            end
        endcase

        // Address phase: reads are answered from this edge, writes land next cycle
        s_d.wr_pend   = 1'b0;
        s_d.hreadyout = 1'b1;
        s_d.hresp     = 1'b0;
        if (hsel && htrans[1] && hready) begin
            s_d.wr_pend = hwrite;
            s_d.wr_addr = haddr[7:0];
            s_d.hrdata  = read_word(s_q, haddr[7:0]);
        end

        s_d.irq = |(s_d.status & s_d.mask);
    end

    // Reset holds every field at a constant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.mode      <= `BMEI_MODE_RST;
            s_q.armed     <= 1'b0;
            s_q.status    <= `BMEI_STATUS_RST;
            s_q.edge_cfg  <= `BMEI_EDGE_RST;
            s_q.mask      <= `BMEI_MASK_RST;
            s_q.std       <= ST_RUN;
            s_q.phase     <= `BMEI_PHASE_RST;
            s_q.wr_pend   <= 1'b0;
            s_q.wr_addr   <= 8'h00;
            s_q.hrdata    <= 32'h0000_0000;
            s_q.hreadyout <= 1'b1;
            s_q.hresp     <= 1'b0;
            s_q.irq       <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata    = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp     = s_q.hresp;
    assign boot_mode = s_q.mode;
    assign irq       = s_q.irq;
    assign std_state = s_q.std;
    assign clk_phase = s_q.phase;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_mode_capture: assert property ($rose(s_q.armed) |-> s_q.mode == $past(ext_int_req_n))
        else $error("mode not captured from pins at release");
    a_mode_stable: assert property (s_q.armed |=> $stable(s_q.mode))
        else $error("mode changed after release");
    a_no_early_req: assert property (!s_q.armed |-> s_q.status == 4'h0)
        else $error("request taken before release");
    a_level_set: assert property (s_q.armed && !s_q.edge_cfg[1] && !ext_int_req_n[1]
        |=> s_q.status[1])
        else $error("level request not recorded");
    a_edge_latch: assert property (s_q.armed && s_q.edge_cfg[0] && $past(ext_int_req_n[0])
        && !ext_int_req_n[0] |=> s_q.status[0] [*2])
        else $error("falling edge not latched");
    a_edge_clear: assert property (s_q.wr_pend && s_q.wr_addr == `BMEI_OFS_STATUS
        && hwdata[2] && s_q.edge_cfg[2] && ext_int_req_n[2] && $past(ext_int_req_n[2])
        |=> !s_q.status[2])
        else $error("serviced edge request not cleared");
    a_irq_mask: assert property (s_q.irq == |(s_q.status & s_q.mask))
        else $error("irq does not follow masked status");
    a_stop_wake: assert property (s_q.std == ST_STOP && !ext_int_req_n[0]
        |=> s_q.std == ST_RUN)
        else $error("first request did not end STOP");
    a_wait_wake: assert property (s_q.std == ST_WAIT && ext_int_req_n[3:1] != 3'h7
        |=> s_q.std == ST_RUN)
        else $error("request did not end WAIT");
    a_stop_hold: assert property (s_q.std == ST_STOP && ext_int_req_n[0] && !s_q.wr_pend
        |=> s_q.std == ST_STOP)
        else $error("STOP left without first request");
    // The first edge after release still shows the reset value, so it is skipped
    a_phase_step: assert property ($past(hresetn) |-> clk_phase == 2'($past(clk_phase) + 2'h1))
        else $error("phase generator did not advance");

    c_capture: cover property ($rose(s_q.armed));
    c_stop_wake: cover property (s_q.std == ST_STOP ##1 s_q.std == ST_RUN);
    c_edge_irq: cover property (s_q.edge_cfg[0] && $rose(s_q.irq));
    c_wait_wake: cover property (s_q.std == ST_WAIT ##1 s_q.std == ST_RUN);

endmodule

`default_nettype wire

/* verification/bmei_board_model.sv */
`timescale 1ns/10ps
`default_nettype none

module bmei_board_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] strap,
    input  wire logic [3:0] req_n,
    output logic [3:0]      pins_n
);
    logic hold_q;

    // Straps outlive release by one edge, so the capture edge still sees them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 1'b1;
        end else begin
            hold_q <= 1'b0;
        end
    end

    assign pins_n = hold_q ? strap : req_n;
endmodule

`default_nettype wire

/* verification/boot_mode_and_ext_irq_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bmei_params.svh"

module boot_mode_and_ext_irq_tb;
    import bmei_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, clk_phase;
    logic [2:0]  hsize;
    logic [3:0]  pins_n, boot_mode, strap, req_n;
    bmei_std_t   std_state;
    int          n_mismatch, n_tests;

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end

    bmei_board_model brd (.hclk(hclk), .hresetn(hresetn), .strap(strap), .req_n(req_n),
                          .pins_n(pins_n));
    bmei_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
                  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
                  .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
                  .ext_int_req_n(pins_n), .boot_mode(boot_mode), .irq(irq),
                  .std_state(std_state), .clk_phase(clk_phase));

    // Only the watchdog ends a wait that never gets an answer
    task automatic wait_rdy;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic pins(input logic [3:0] v);
        @(posedge hclk);
        req_n <= v;
        repeat (3) @(posedge hclk);
        #1;
    endtask

    task automatic t_boot(input logic [3:0] code);
        @(posedge hclk);
        hresetn <= 1'b0;
        strap <= code;
        repeat (2) @(posedge hclk);
        #1;
        `CHK(clk_phase, 2'h0)
        `CHK(std_state, ST_RUN)
        `CHK(irq, 1'b0)
        `CHK(hreadyout, 1'b1)
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        #1;
        `CHK(boot_mode, code)
        `CHK(clk_phase, 2'h3)
        bus(1'b1, `BMEI_OFS_MODE, {28'h0, ~code});
        bus(1'b0, `BMEI_OFS_MODE, 32'h0);
        `CHK(rd, {28'h0, code})
    endtask

    task automatic t_level;
        bus(1'b1, `BMEI_OFS_MASK, 32'h2);
        pins(4'h9);
        bus(1'b0, `BMEI_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h6)
        `CHK(irq, 1'b1)
        bus(1'b1, `BMEI_OFS_STATUS, 32'h6);
        bus(1'b0, `BMEI_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h6)
        pins(4'hB);
        bus(1'b1, `BMEI_OFS_STATUS, 32'h6);
        #1;
        `CHK(irq, 1'b0)
        bus(1'b0, `BMEI_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h4)
        bus(1'b0, 8'h20, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(hresp, 1'b0)
        pins(4'hF);
        bus(1'b1, `BMEI_OFS_STATUS, 32'hF);
    endtask

    task automatic t_edge;
        bus(1'b1, `BMEI_OFS_EDGE, 32'h5);
        bus(1'b1, `BMEI_OFS_MASK, 32'h1);
        pins(4'hE);
        `CHK(irq, 1'b1)
        bus(1'b1, `BMEI_OFS_STATUS, 32'h5);
        bus(1'b0, `BMEI_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(irq, 1'b0)
        pins(4'hF);
        bus(1'b0, `BMEI_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, `BMEI_OFS_EDGE, 32'h0);
        bus(1'b1, `BMEI_OFS_MASK, 32'h0);
    endtask

    task automatic t_wake;
        bus(1'b1, `BMEI_OFS_STANDBY, 32'h2);
        #1;
        `CHK(std_state, ST_STOP)
        pins(4'hD);
        `CHK(std_state, ST_STOP)
        pins(4'hF);
        pins(4'hE);
        `CHK(std_state, ST_RUN)
        pins(4'hF);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `BMEI_OFS_STANDBY, 32'h1);
            bus(1'b0, `BMEI_OFS_STANDBY, 32'h0);
            `CHK(rd, 32'h1)
            pins(~(4'h1 << i));
            `CHK(std_state, ST_RUN)
            pins(4'hF);
        end
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    initial begin
        repeat (4000) @(posedge hclk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {hresetn, hsel, hwrite} = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        strap = 4'hA;
        req_n = 4'hF;
        n_mismatch = 0;
        n_tests = 0;
        t_boot(4'hA);
        t_level();
        t_edge();
        t_wake();
        t_boot(4'h5);
        wrap_up();
    end
endmodule

`default_nettype wire
